// [rtl/hof_pkg.sv]
// Package of constants and types for the hardware option fuse block.
package hof_pkg;

  // ************************************************************
  // APB register map.
  // ************************************************************
  localparam logic [7:0] HOF_ADDR_FUSE = 8'h00;
  localparam logic [7:0] HOF_ADDR_STAT = 8'h04;
  localparam logic [7:0] HOF_ADDR_WDT = 8'h08;
  localparam logic [7:0] HOF_ADDR_IAP = 8'h0C;
  localparam logic [7:0] HOF_ADDR_CODE = 8'h10;

  // ************************************************************
  // Flash layout.
  // ************************************************************
  localparam logic [13:0] HOF_FLASH_END = 14'h3FFF;
  localparam logic [13:0] HOF_ISP_BASE = 14'h2200;
  localparam logic [13:0] HOF_ISP_STEP = 14'h0200;
  localparam logic [3:0] HOF_ISP_NONE = 4'h0;
  localparam logic [3:0] HOF_ISP_MAX = 4'hF;
  localparam logic [3:0] HOF_ISP_DEFAULT = 4'hD;
  localparam logic [7:0] HOF_LOCK_BYTE = 8'hFF;
  localparam logic [3:0] HOF_IAP_DEFAULT = 4'h2;

  // ************************************************************
  // Brown-out threshold codes and watchdog control fields.
  // ************************************************************
  localparam logic [1:0] HOF_BOD_2V0 = 2'h0;
  localparam logic [1:0] HOF_BOD_2V4 = 2'h1;
  localparam logic [1:0] HOF_BOD_3V7 = 2'h2;
  localparam logic [1:0] HOF_BOD_4V2 = 2'h3;
  localparam logic [7:0] HOF_WDT_PROT_MASK = 8'hCF;
  localparam logic [1:0] HOF_SAMPLE_CYCLES = 2'h3;

  // Fuse word as delivered by the programming path; 1 means enabled.
  typedef struct packed {
    logic lock;
    logic [3:0] isp_size;
    logic boot_isp_on_powerup_fuse;
    logic boot_isp_on_any_reset_fuse;
    logic [3:0] iap_size;
    logic high_brownout_detector_level_select_hi;
    logic high_brownout_detector_level_select_lo;
    logic low_brownout_reset_fuse;
    logic high_brownout_reset_fuse;
    logic watchdog_reset_enable_fuse;
    logic watchdog_nonstop_fuse;
    logic watchdog_auto_enable_fuse;
    logic watchdog_idle_run_fuse;
    logic watchdog_prescale_fuse_2;
    logic watchdog_prescale_fuse_1;
    logic watchdog_prescale_fuse_0;
    logic watchdog_write_protect_fuse;
  } hof_fuse_t;

  // Watchdog control register layout.
  typedef struct packed {
    logic watchdog_reset_enable_bit;
    logic watchdog_nonstop_bit;
    logic watchdog_enable_bit;
    logic watchdog_overflow_flag;
    logic watchdog_idle_run_bit;
    logic watchdog_prescale_bit_2;
    logic watchdog_prescale_bit_1;
    logic watchdog_prescale_bit_0;
  } hof_watchdog_control_register_t;

  typedef enum logic [1:0] {
    HOF_ST_SAMPLE = 2'b00,
    HOF_ST_LOAD = 2'b01,
    HOF_ST_RUN = 2'b11
  } hof_state_t;

endpackage

// [rtl/hof_sync.sv]
// Two-stage synchroniser for a bus of asynchronous levels.
`timescale 1ns/100ps
module hof_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end

endmodule

// [rtl/hof_core.sv]
// Hardware option fuse block: sampling, decode, boot and watchdog defaults.
`timescale 1ns/100ps
module hof_core
  import hof_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Reset causes
  input wire logic por_event,
  input wire logic sys_reset_event,
  // Fuse array and detectors
  input wire hof_fuse_t fuse_in,
  input wire logic low_brownout_detector_trip,
  input wire logic high_brownout_detector_trip,
  input wire logic wdt_overflow,
  // Programmer code read path
  input wire logic [7:0] code_raw,
  output logic [7:0] code_out,
  // Boot and reset outputs
  output logic cpu_hold,
  output logic boot_from_isp,
  output logic bod_reset_req,
  output logic [13:0] isp_start,
  output logic isp_present,
  output logic [1:0] high_brownout_detector_level,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ************************************************************
  // Input synchronisation.
  // ************************************************************
  localparam int SW = $bits(hof_fuse_t) + 5;
  logic [SW-1:0] sync_q;
  hof_fuse_t fuse_s;
  logic por_s, rst_s, low_brownout_detector_s, high_brownout_detector_s, wdto_s;

  hof_sync #(.W(SW)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d({fuse_in, por_event, sys_reset_event, low_brownout_detector_trip, high_brownout_detector_trip,
        wdt_overflow}),
    .q(sync_q)
  );
  assign {fuse_s, por_s, rst_s, low_brownout_detector_s, high_brownout_detector_s, wdto_s} = sync_q;

  // ************************************************************
  // Sequencer and sampled fuses.
  // ************************************************************
  hof_state_t state_reg, state_next;
  hof_fuse_t fuse_reg, fuse_next;
  logic [1:0] cnt_reg, cnt_next;
  logic por_seen_reg, por_seen_next;
  logic cold_reg, cold_next;

  always_comb begin
    state_next = state_reg;
    fuse_next = fuse_reg;
    cnt_next = cnt_reg;
    por_seen_next = por_seen_reg;
    cold_next = cold_reg;
    if (por_s) begin
      state_next = HOF_ST_SAMPLE;
      cnt_next = '0;
      por_seen_next = 1'b1;
    end else if (rst_s) begin
      state_next = HOF_ST_LOAD;
      cold_next = 1'b0;
    end else begin
      unique case (state_reg)
        HOF_ST_SAMPLE: begin
          fuse_next = fuse_s;
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == HOF_SAMPLE_CYCLES) begin
            state_next = HOF_ST_LOAD;
            cold_next = por_seen_reg;
            por_seen_next = 1'b0;
          end
        end
        HOF_ST_LOAD: state_next = HOF_ST_RUN;
        HOF_ST_RUN: state_next = HOF_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= HOF_ST_SAMPLE;
      fuse_reg <= '0;
      cnt_reg <= '0;
      por_seen_reg <= 1'b1;
      cold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fuse_reg <= fuse_next;
      cnt_reg <= cnt_next;
      por_seen_reg <= por_seen_next;
      cold_reg <= cold_next;
    end
  end

  // ************************************************************
  // Decode of sampled options.
  // ************************************************************
  logic isp_on;
  logic [13:0] isp_addr;
  logic [1:0] lvl;
  logic boot_isp;
  assign isp_on = (fuse_reg.isp_size != HOF_ISP_NONE);
  // Code 1 is 7.5K at 2200h; each step up adds 200h.
  assign isp_addr = isp_on ? 14'(HOF_ISP_BASE + HOF_ISP_STEP *
                    14'(fuse_reg.isp_size - 4'h1)) : HOF_FLASH_END;
  always_comb begin
    unique case ({fuse_reg.high_brownout_detector_level_select_hi,
                  fuse_reg.high_brownout_detector_level_select_lo})
      2'b11: lvl = HOF_BOD_2V0;
      2'b10: lvl = HOF_BOD_2V4;
      2'b01: lvl = HOF_BOD_3V7;
      default: lvl = HOF_BOD_4V2;
    endcase
  end
  assign boot_isp = isp_on && ((fuse_reg.boot_isp_on_any_reset_fuse) ||
                    (fuse_reg.boot_isp_on_powerup_fuse && cold_reg));

  // ************************************************************
  // Watchdog control and IAP boundary registers.
  // ************************************************************
  hof_watchdog_control_register_t wdt_reg, wdt_next, wdt_load;
  logic [3:0] iap_reg, iap_next;
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;

  always_comb begin
    wdt_load = '0;
    wdt_load.watchdog_reset_enable_bit = fuse_reg.watchdog_reset_enable_fuse;
    wdt_load.watchdog_nonstop_bit = fuse_reg.watchdog_nonstop_fuse;
    if (fuse_reg.watchdog_auto_enable_fuse) begin
      wdt_load.watchdog_enable_bit = 1'b1;
      wdt_load.watchdog_idle_run_bit = fuse_reg.watchdog_idle_run_fuse;
      wdt_load.watchdog_prescale_bit_2 = fuse_reg.watchdog_prescale_fuse_2;
      wdt_load.watchdog_prescale_bit_1 = fuse_reg.watchdog_prescale_fuse_1;
      wdt_load.watchdog_prescale_bit_0 = fuse_reg.watchdog_prescale_fuse_0;
    end
  end

  always_comb begin
    wdt_next = wdt_reg;
    iap_next = iap_reg;
    if (state_reg == HOF_ST_LOAD) begin
      wdt_next = wdt_load;
      iap_next = fuse_reg.iap_size;
    end else if (state_reg == HOF_ST_RUN) begin
      if (wr_acc && paddr == HOF_ADDR_WDT) begin
        if (fuse_reg.watchdog_write_protect_fuse) begin
          wdt_next = (wdt_reg & HOF_WDT_PROT_MASK) |
                     (pwdata[7:0] & ~HOF_WDT_PROT_MASK);
        end else begin
          wdt_next = pwdata[7:0];
        end
        // Flag is write-one-to-clear; a new overflow still wins.
        wdt_next.watchdog_overflow_flag = wdt_reg.watchdog_overflow_flag &
                                          ~pwdata[4];
      end
      if (wr_acc && paddr == HOF_ADDR_IAP) begin
        iap_next = pwdata[3:0];
      end
      if (wdto_s) begin
        wdt_next.watchdog_overflow_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdt_reg <= '0;
      iap_reg <= HOF_IAP_DEFAULT;
    end else begin
      wdt_reg <= wdt_next;
      iap_reg <= iap_next;
    end
  end

  // ************************************************************
  // Registered outputs.
  // ************************************************************
  logic [7:0] code_next;
  logic bodr_next, hold_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next, rd_sel;
  assign hold_next = (state_next != HOF_ST_RUN);
  assign code_next = fuse_reg.lock ? HOF_LOCK_BYTE : code_raw;
  assign bodr_next = (state_reg == HOF_ST_RUN) &&
                     ((low_brownout_detector_s && fuse_reg.low_brownout_reset_fuse) ||
                      (high_brownout_detector_s && fuse_reg.high_brownout_reset_fuse));
  assign rd_sel = psel && !penable;

  always_comb begin
    prdata_next = '0;
    pslverr_next = 1'b0;
    unique case (paddr)
      HOF_ADDR_FUSE: prdata_next = 32'(fuse_reg);
      HOF_ADDR_STAT: prdata_next = {16'h0000, 2'(state_reg), lvl,
                                    cold_reg, boot_isp, isp_on, 9'h000};
      HOF_ADDR_WDT: prdata_next = {24'h000000, wdt_reg};
      HOF_ADDR_IAP: prdata_next = {28'h0000000, iap_reg};
      HOF_ADDR_CODE: prdata_next = {24'h000000, code_out};
      default: pslverr_next = 1'b1;
    endcase
    if (!rd_sel || pwrite) begin
      prdata_next = '0;
    end
    // Fuse word is read-only: writing it is answered with an error.
    if (rd_sel && pwrite && paddr == HOF_ADDR_FUSE) begin
      pslverr_next = 1'b1;
    end
    if (!rd_sel) begin
      pslverr_next = 1'b0;
    end
  end
  assign pready_next = rd_sel;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      code_out <= HOF_LOCK_BYTE;
      cpu_hold <= 1'b1;
      boot_from_isp <= 1'b0;
      bod_reset_req <= 1'b0;
      isp_start <= HOF_FLASH_END;
      isp_present <= 1'b0;
      high_brownout_detector_level <= HOF_BOD_4V2;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      code_out <= code_next;
      cpu_hold <= hold_next;
      boot_from_isp <= boot_isp;
      bod_reset_req <= bodr_next;
      isp_start <= isp_addr;
      isp_present <= isp_on;
      high_brownout_detector_level <= lvl;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  property p_lock_ff;
    @(posedge clk_sys) disable iff (!rst_b)
      fuse_reg.lock |=> code_out == HOF_LOCK_BYTE;
  endproperty
  a_lock_ff: assert property (p_lock_ff) else $error("lock not 0xFF");

  property p_isp_addr;
    @(posedge clk_sys) disable iff (!rst_b)
      (fuse_reg.isp_size == HOF_ISP_MAX) |=> isp_start == 14'h3E00;
  endproperty
  a_isp_addr: assert property (p_isp_addr) else $error("isp start");

  property p_no_isp_boot;
    @(posedge clk_sys) disable iff (!rst_b)
      !isp_on |=> !boot_from_isp;
  endproperty
  a_no_isp_boot: assert property (p_no_isp_boot) else $error("boot");

  property p_any_reset;
    @(posedge clk_sys) disable iff (!rst_b)
      (isp_on && fuse_reg.boot_isp_on_any_reset_fuse) |=> boot_from_isp;
  endproperty
  a_any_reset: assert property (p_any_reset) else $error("anyreset");

  property p_bod_off;
    @(posedge clk_sys) disable iff (!rst_b)
      !fuse_reg.low_brownout_reset_fuse && !fuse_reg.high_brownout_reset_fuse
      |=> !bod_reset_req;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("bod reset");

  property p_high_brownout_detector_on;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_reg == HOF_ST_RUN && high_brownout_detector_s &&
       fuse_reg.high_brownout_reset_fuse) |=> bod_reset_req;
  endproperty
  a_high_brownout_detector_on: assert property (p_high_brownout_detector_on) else $error("high_brownout_detector reset");

  property p_wdt_load;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_reg == HOF_ST_LOAD && !por_s && !rst_s) |=>
      wdt_reg.watchdog_reset_enable_bit ==
        $past(fuse_reg.watchdog_reset_enable_fuse) &&
      wdt_reg.watchdog_enable_bit ==
        $past(fuse_reg.watchdog_auto_enable_fuse);
  endproperty
  a_wdt_load: assert property (p_wdt_load) else $error("wdt load");

  property p_wp;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_reg == HOF_ST_RUN && fuse_reg.watchdog_write_protect_fuse &&
       !por_s && !rst_s) |=> $stable(wdt_reg & HOF_WDT_PROT_MASK);
  endproperty
  a_wp: assert property (p_wp) else $error("wdt protect");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (state_reg == HOF_ST_SAMPLE) |=> cpu_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu hold");

endmodule

// [bench/hof_prog_model.sv]
// Programmer model that burns the fuse word and presents flash bytes.
`timescale 1ns/100ps
module hof_prog_model
  import hof_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Fuse array and flash byte
  output hof_fuse_t fuse_word,
  output logic [7:0] code_byte
);
  // An erased part has every fuse off.
  initial begin
    fuse_word = '0;
    code_byte = 8'h00;
  end

  // The programmer is the only writer of the fuse array.
  task automatic burn(input hof_fuse_t f);
    @(posedge clk_sys);
    fuse_word <= f;
  endtask

  task automatic show(input logic [7:0] b);
    @(posedge clk_sys);
    code_byte <= b;
  endtask
endmodule

// [bench/hardware_option_fuses_tb_top.sv]
// Self-checking testbench for the hardware option fuse block.
`timescale 1ns/100ps
module hardware_option_fuses_tb_top;
  import hof_pkg::*;

  // ************************************************************
  // Signals and instances.
  // ************************************************************
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic por_event = 1'b1;
  logic sys_reset_event = 1'b0;
  logic low_brownout_detector_trip = 1'b0;
  logic high_brownout_detector_trip = 1'b0;
  logic wdt_overflow = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  hof_fuse_t fuse_w;
  logic [7:0] code_b, code_out, paddr_u;
  logic cpu_hold, boot_from_isp, bod_reset_req, isp_present;
  logic [13:0] isp_start;
  logic [1:0] high_brownout_detector_level;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 clk_sys = ~clk_sys;

  hof_prog_model prog (.clk_sys(clk_sys), .fuse_word(fuse_w),
    .code_byte(code_b));

  hof_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .por_event(por_event),
    .sys_reset_event(sys_reset_event), .fuse_in(fuse_w),
    .low_brownout_detector_trip(low_brownout_detector_trip), .high_brownout_detector_trip(high_brownout_detector_trip),
    .wdt_overflow(wdt_overflow), .code_raw(code_b), .code_out(code_out),
    .cpu_hold(cpu_hold), .boot_from_isp(boot_from_isp),
    .bod_reset_req(bod_reset_req), .isp_start(isp_start),
    .isp_present(isp_present), .high_brownout_detector_level(high_brownout_detector_level), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ************************************************************
  // Shared tasks.
  // ************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high or 16 edges have passed.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let one edge pass so a following call never re-drives psel at once.
    @(posedge clk_sys);
  endtask

  // Power-on sequence; the first fetch waits for cpu_hold to drop.
  task automatic power_on(input hof_fuse_t f);
    int n;
    n = 0;
    prog.burn(f);
    rst_b <= 1'b0;
    por_event <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    por_event <= 1'b0;
    repeat (3) @(posedge clk_sys);
    while (cpu_hold !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("cpu_hold", 32'h0, {31'h0, cpu_hold});
    @(posedge clk_sys);
  endtask

  task automatic warm_reset();
    sys_reset_event <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_reset_event <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_erased();
    power_on('0);
    chk("isp_present", 32'h0, {31'h0, isp_present});
    chk("isp_start", 32'h3FFF, {18'h0, isp_start});
    chk("boot", 32'h0, {31'h0, boot_from_isp});
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt", 32'h0, rd);
    prog.show(8'h5A);
    repeat (3) @(posedge clk_sys);
    chk("code_out", 32'h5A, {24'h0, code_out});
  endtask

  task automatic t_isp();
    hof_fuse_t f;
    f = '0;
    for (int i = 1; i < 16; i++) begin
      f.isp_size = 4'(i);
      power_on(f);
      chk("isp_start", 32'h2200 + 32'(i - 1) * 32'h200,
          {18'h0, isp_start});
      chk("isp_present", 32'h1, {31'h0, isp_present});
    end
    f.isp_size = HOF_ISP_DEFAULT;
    power_on(f);
    chk("isp_default", 32'h3A00, {18'h0, isp_start});
  endtask

  task automatic t_lock();
    hof_fuse_t f;
    f = '0;
    f.lock = 1'b1;
    power_on(f);
    prog.show(8'hA5);
    repeat (3) @(posedge clk_sys);
    chk("code_lock", 32'hFF, {24'h0, code_out});
    // Clearing the fuse without a power-on must change nothing.
    prog.burn('0);
    prog.show(8'h3C);
    repeat (6) @(posedge clk_sys);
    chk("code_held", 32'hFF, {24'h0, code_out});
  endtask

  task automatic t_boot();
    hof_fuse_t f;
    f = '0;
    f.isp_size = 4'h3;
    f.boot_isp_on_powerup_fuse = 1'b1;
    power_on(f);
    chk("boot_por", 32'h1, {31'h0, boot_from_isp});
    warm_reset();
    chk("boot_warm", 32'h0, {31'h0, boot_from_isp});
    f.boot_isp_on_powerup_fuse = 1'b0;
    f.boot_isp_on_any_reset_fuse = 1'b1;
    power_on(f);
    chk("boot_any_por", 32'h1, {31'h0, boot_from_isp});
    warm_reset();
    chk("boot_any_warm", 32'h1, {31'h0, boot_from_isp});
    f.boot_isp_on_powerup_fuse = 1'b1;
    f.isp_size = HOF_ISP_NONE;
    power_on(f);
    chk("boot_no_isp", 32'h0, {31'h0, boot_from_isp});
  endtask

  task automatic t_bod();
    hof_fuse_t f;
    logic [1:0] lv [4];
    lv = '{HOF_BOD_4V2, HOF_BOD_3V7, HOF_BOD_2V4, HOF_BOD_2V0};
    f = '0;
    for (int i = 0; i < 4; i++) begin
      f.high_brownout_detector_level_select_hi = i[1];
      f.high_brownout_detector_level_select_lo = i[0];
      power_on(f);
      chk("high_brownout_detector_level", {30'h0, lv[i]}, {30'h0, high_brownout_detector_level});
    end
    for (int j = 0; j < 2; j++) begin
      f.low_brownout_reset_fuse = j[0];
      f.high_brownout_reset_fuse = j[0];
      power_on(f);
      low_brownout_detector_trip <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("low_brownout_detector_req", 32'(j), {31'h0, bod_reset_req});
      low_brownout_detector_trip <= 1'b0;
      repeat (6) @(posedge clk_sys);
      high_brownout_detector_trip <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("high_brownout_detector_req", 32'(j), {31'h0, bod_reset_req});
      high_brownout_detector_trip <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask

  task automatic t_wdt();
    hof_fuse_t f;
    f = '0;
    f.watchdog_auto_enable_fuse = 1'b1;
    f.watchdog_reset_enable_fuse = 1'b1;
    f.watchdog_nonstop_fuse = 1'b1;
    f.watchdog_idle_run_fuse = 1'b1;
    f.watchdog_prescale_fuse_2 = 1'b1;
    f.watchdog_prescale_fuse_0 = 1'b1;
    power_on(f);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_auto", 32'hED, rd);
    f.watchdog_write_protect_fuse = 1'b1;
    power_on(f);
    apb(1'b1, HOF_ADDR_WDT, 32'h0);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_prot", 32'hCD, rd & 32'hCF);
    f.watchdog_write_protect_fuse = 1'b0;
    power_on(f);
    apb(1'b1, HOF_ADDR_WDT, 32'h0);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_free", 32'h0, rd & 32'hCF);
    f.watchdog_auto_enable_fuse = 1'b0;
    f.watchdog_nonstop_fuse = 1'b0;
    power_on(f);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_manual", 32'h80, rd);
    wdt_overflow <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wdt_overflow <= 1'b0;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_ovf_set", 32'h90, rd);
    apb(1'b1, HOF_ADDR_WDT, 32'h90);
    apb(1'b0, HOF_ADDR_WDT, 32'h0);
    chk("wdt_ovf_clear", 32'h80, rd);
  endtask

  task automatic t_regs();
    hof_fuse_t f;
    f = '0;
    f.lock = 1'b1;
    f.isp_size = 4'h5;
    f.iap_size = 4'h5;
    power_on(f);
    apb(1'b1, HOF_ADDR_FUSE, 32'h0);
    chk("fuse_wr_err", 32'h1, {31'h0, err});
    apb(1'b0, HOF_ADDR_FUSE, 32'h0);
    chk("fuse_word", 32'(f), rd);
    apb(1'b0, HOF_ADDR_STAT, 32'h0);
    chk("status", 32'hFA00, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b0, HOF_ADDR_IAP, 32'h0);
    chk("iap_fuse", 32'h5, rd & 32'hF);
    apb(1'b1, HOF_ADDR_IAP, 32'h7);
    apb(1'b0, HOF_ADDR_IAP, 32'h0);
    chk("iap_sw", 32'h7, rd & 32'hF);
  endtask

  // ************************************************************
  // Main sequence and hang guard.
  // ************************************************************
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    por_event <= 1'b0;
    t_erased();
    t_isp();
    t_lock();
    t_boot();
    t_bod();
    t_wdt();
    t_regs();
    test_done();
  end
endmodule
